// ---- hdl/irq_status_consts.svh ----
// Offsets, field positions and reset values of the control port interrupt registers
`ifndef IRQ_STATUS_CONSTS_SVH
`define IRQ_STATUS_CONSTS_SVH

// ==========================================
// Register offsets from the control port base
`define STATUS_OFFSET        8'h40
`define MASK_OFFSET          8'h41

// ==========================================
// Field positions
`define PARITY_BIT           0
`define CLASH_BIT            1
`define GENERAL_SUMMARY_BIT  2
`define PORT_SUMMARY_LO      4
`define PORT_SUMMARY_HI      6

// ==========================================
// Reset values and widths
`define EVENT_FLAG_COUNT     2
`define DATA_PORT_COUNT      3
`define FLAG_RESET           2'h0
`define MASK_RESET           2'h0
`define READ_RESET           8'h00

`endif

// ---- hdl/irq_status_pkg.sv ----
// Types shared by the control port interrupt status logic
package irq_status_pkg;

  typedef logic [7:0] reg_byte_type;

  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_STATUS = 2'b01,
    SEL_MASK   = 2'b10
  } reg_sel_type;

endpackage : irq_status_pkg

// ---- hdl/event_flag_if.sv ----
// Link between the register front end and the sticky event flag bank
`timescale 1ns/1ps

interface event_flag_if #(
  parameter int N = 2
);
  logic [N-1:0] event_in;
  logic [N-1:0] clear;
  logic [N-1:0] mask;
  logic [N-1:0] flag;
  logic         irq_any;

  modport front (output event_in, output clear, output mask, input flag, input irq_any);
  modport bank  (input event_in, input clear, input mask, output flag, output irq_any);
endinterface : event_flag_if

// ---- hdl/event_flag_bank.sv ----
// Sticky write-one-to-clear event flags with per-flag mask
`timescale 1ns/1ps
`include "irq_status_consts.svh"

module event_flag_bank #(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Flag link
  event_flag_if.bank link
);

  // ==========================================
  // One sticky flag per event
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      logic bit_reg;
      // Set beats clear so an event in the clearing cycle is never lost
      always_ff @(posedge clk) begin
        if (rst) begin
          bit_reg <= 1'b0;
        end else if (link.event_in[i]) begin
          bit_reg <= 1'b1;
        end else if (link.clear[i]) begin
          bit_reg <= 1'b0;
        end
      end
      assign link.flag[i] = bit_reg;

      property p_set_beats_clear;
        @(posedge clk) disable iff (rst)
        (link.event_in[i] && link.clear[i]) |=> link.flag[i];
      endproperty
      a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("flag lost an event arriving with its clear");
    end
  endgenerate

  // ==========================================
  // Masked pending flags
  assign link.irq_any = |(link.flag & link.mask);

endmodule : event_flag_bank

// ---- hdl/irq_status_port.sv ----
// Control port interrupt status and mask registers with interrupt request
`timescale 1ns/1ps
`include "irq_status_consts.svh"

module irq_status_port #(
  parameter int PORTS = `DATA_PORT_COUNT
) (
  // Clock and reset
  input  wire  logic             clk,
  input  wire  logic             rst,
  // Register access
  input  wire  logic [7:0]       reg_addr,
  input  wire  logic             reg_wr,
  input  wire  logic [7:0]       reg_wdata,
  input  wire  logic             reg_rd,
  output logic       [7:0]       reg_rdata,
  // Bus error detectors
  input  wire  logic             bus_clash_detect,
  input  wire  logic             parity_error_detect,
  input  wire  logic             sync_loss_rst,
  // Summary sources
  input  wire  logic [PORTS-1:0] data_port_pending,
  input  wire  logic             general_pending,
  // Interrupt request
  output logic                   irq_request
);

  // ==========================================
  // Storage
  logic [`EVENT_FLAG_COUNT-1:0]  mask_reg;
  logic [`EVENT_FLAG_COUNT-1:0]  mask_next;
  irq_status_pkg::reg_byte_type  rdata_reg;
  irq_status_pkg::reg_byte_type  rdata_next;
  logic                          irq_reg;
  logic                          irq_next;

  event_flag_if #(.N(`EVENT_FLAG_COUNT)) flag_link ();

  event_flag_bank #(
    .N    (`EVENT_FLAG_COUNT)
  ) u_flags (
    .clk  (clk),
    .rst  (rst),
    .link (flag_link)
  );

  // ==========================================
  // Address decode
  irq_status_pkg::reg_sel_type   sel;
  wire                           wr_status;
  wire                           wr_mask;
  wire [7:0]                     status_byte;
  wire [7:0]                     mask_byte;
  wire                           summary_any;

  assign sel = (reg_addr == `STATUS_OFFSET) ? irq_status_pkg::SEL_STATUS :
               (reg_addr == `MASK_OFFSET)   ? irq_status_pkg::SEL_MASK   :
                                              irq_status_pkg::SEL_NONE;
  assign wr_status = reg_wr && (sel == irq_status_pkg::SEL_STATUS);
  assign wr_mask   = reg_wr && (sel == irq_status_pkg::SEL_MASK);

  // ==========================================
  // Flag bank hookup
  // Of the two resets only rst clears the flags; sync loss reset deliberately does not reach them
  assign flag_link.event_in = {bus_clash_detect, parity_error_detect};
  assign flag_link.clear    = wr_status ?
                              reg_wdata[`CLASH_BIT:`PARITY_BIT] : 2'h0;
  assign flag_link.mask     = mask_reg;

  // ==========================================
  // Read data composition
  // Summary bits are live views of their sources; writes to them are dropped
  assign status_byte = {1'b0,
                        data_port_pending,
                        1'b0,
                        general_pending,
                        flag_link.flag};
  assign mask_byte   = {6'h00, mask_reg};

  always_comb begin
    case (sel)
      irq_status_pkg::SEL_STATUS: rdata_next = status_byte;
      irq_status_pkg::SEL_MASK:   rdata_next = mask_byte;
      default:                    rdata_next = 8'h00;
    endcase
    if (!reg_rd) begin
      rdata_next = rdata_reg;
    end
  end

  assign mask_next   = wr_mask ? reg_wdata[`CLASH_BIT:`PARITY_BIT] : mask_reg;
  assign summary_any = (|data_port_pending) | general_pending;
  assign irq_next    = flag_link.irq_any | summary_any;

  // ==========================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_reg  <= `MASK_RESET;
      rdata_reg <= `READ_RESET;
      irq_reg   <= 1'b0;
    end else begin
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
    end
  end

  assign reg_rdata   = rdata_reg;
  assign irq_request = irq_reg;

  // ==========================================
  // Checks
  property p_reset_zero;
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> (flag_link.flag == 2'h0) && (mask_reg == 2'h0);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("flags or masks not zero after reset");

  property p_clash_sets;
    @(posedge clk) disable iff (rst)
    bus_clash_detect |=> flag_link.flag[1] ##1 (flag_link.flag[1] || $past(wr_status));
  endproperty
  a_clash_sets: assert property (p_clash_sets)
    else $error("bus clash did not set and hold its flag");

  property p_parity_sets;
    @(posedge clk) disable iff (rst)
    parity_error_detect |=> flag_link.flag[0];
  endproperty
  a_parity_sets: assert property (p_parity_sets)
    else $error("parity error did not set its flag");

  property p_w1c_clears;
    @(posedge clk) disable iff (rst)
    (wr_status && reg_wdata[1] && !bus_clash_detect) |=> !flag_link.flag[1];
  endproperty
  a_w1c_clears: assert property (p_w1c_clears)
    else $error("write one did not clear clash flag");

  property p_w0_holds;
    @(posedge clk) disable iff (rst)
    (flag_link.flag[0] && !(wr_status && reg_wdata[0])) |=> flag_link.flag[0];
  endproperty
  a_w0_holds: assert property (p_w0_holds)
    else $error("parity flag dropped without a write one");

  property p_sync_loss_keeps;
    @(posedge clk) disable iff (rst)
    (sync_loss_rst && !wr_status) |=> (flag_link.flag == $past(flag_link.flag)) ||
                                      $past(bus_clash_detect || parity_error_detect);
  endproperty
  a_sync_loss_keeps: assert property (p_sync_loss_keeps)
    else $error("sync loss reset changed an event flag");

  property p_masked_quiet;
    @(posedge clk) disable iff (rst)
    (((flag_link.flag & mask_reg) == 2'h0) && !summary_any) |=> !irq_request;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt raised by a masked flag");

  property p_unmasked_raises;
    @(posedge clk) disable iff (rst)
    (flag_link.flag[0] && mask_reg[0]) |=> irq_request;
  endproperty
  a_unmasked_raises: assert property (p_unmasked_raises)
    else $error("unmasked parity flag gave no interrupt");

  property p_port_summary_read;
    @(posedge clk) disable iff (rst)
    (reg_rd && sel == irq_status_pkg::SEL_STATUS) |=>
      reg_rdata[6:4] == $past(data_port_pending);
  endproperty
  a_port_summary_read: assert property (p_port_summary_read)
    else $error("data port summary read wrong");

  property p_general_read;
    @(posedge clk) disable iff (rst)
    (reg_rd && sel == irq_status_pkg::SEL_STATUS) |=> reg_rdata[2] == $past(general_pending);
  endproperty
  a_general_read: assert property (p_general_read)
    else $error("general summary read wrong");

  property p_summary_irq;
    @(posedge clk) disable iff (rst)
    summary_any |=> irq_request;
  endproperty
  a_summary_irq: assert property (p_summary_irq)
    else $error("summary flag gave no interrupt");

  property p_unmasked_clash;
    @(posedge clk) disable iff (rst)
    (flag_link.flag[1] && mask_reg[1]) |=> irq_request;
  endproperty
  a_unmasked_clash: assert property (p_unmasked_clash)
    else $error("unmasked clash flag gave no interrupt");

  property p_w1c_parity;
    @(posedge clk) disable iff (rst)
    (wr_status && reg_wdata[0] && !parity_error_detect) |=> !flag_link.flag[0];
  endproperty
  a_w1c_parity: assert property (p_w1c_parity)
    else $error("write one did not clear parity flag");

  property p_mask_write;
    @(posedge clk) disable iff (rst)
    wr_mask |=> mask_reg == $past(reg_wdata[`CLASH_BIT:`PARITY_BIT]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write did not land");

endmodule : irq_status_port

// ---- tb/ctrl_master_model.sv ----
// Control port bus master model issuing single-byte register cycles
`timescale 1ns/1ps
`include "irq_status_consts.svh"

module ctrl_master_model (
  // Clock
  input  wire logic       clk,
  // Register access
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // ==========================================
  // Bus cycles
  // Released data is inverted so a stale value can never look valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = (a == `STATUS_OFFSET) ? (d & 8'h77) : (d & 8'h03);
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask : read_reg
endmodule : ctrl_master_model

// ---- tb/test_irq_status_port.sv ----
// Self-checking bench for the control port interrupt status block
`timescale 1ns/1ps
`include "irq_status_consts.svh"

module test_irq_status_port;
  logic       clk;
  logic       rst;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       bus_clash_detect;
  logic       parity_error_detect;
  logic       sync_loss_rst;
  logic [2:0] data_port_pending;
  logic       general_pending;
  logic       irq_request;
  logic       clash_bit;
  logic [7:0] exp_q[$];
  logic       rd_pend;
  logic       rd_now;
  int         bad_count;
  int         total_checks;
  int         seed;
  int         i;

  irq_status_port u_irq_status_port (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_clash_detect(bus_clash_detect), .parity_error_detect(parity_error_detect),
    .sync_loss_rst(sync_loss_rst), .data_port_pending(data_port_pending),
    .general_pending(general_pending), .irq_request(irq_request));

  ctrl_master_model u_ctrl_master_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================
  // Compare and report
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check_byte

  task automatic check_irq(input logic exp);
    total_checks++;
    if (irq_request !== exp) begin
      bad_count++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, irq_request);
    end
  endtask : check_irq

  // ==========================================
  // Stimulus helpers
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_ctrl_master_model.read_reg(a);
  endtask : rd

  task automatic ev(input logic clash, input logic par);
    @(negedge clk);
    bus_clash_detect    = clash;
    parity_error_detect = par;
    @(negedge clk);
    bus_clash_detect    = 1'b0;
    parity_error_detect = 1'b0;
  endtask : ev

  // Read data lands on the edge that took the read and is checked one edge later
  always @(posedge clk) begin
    rd_now  = rd_pend;
    rd_pend = reg_rd;
    if (rd_now) begin
      #1;
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("unexpected at %0t: expected %h got %h", $time, 8'h00, reg_rdata);
      end else begin
        check_byte(exp_q.pop_front(), reg_rdata);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  // ==========================================
  // Main sequence
  initial begin
    seed = 7;
    rd_pend = 1'b0;
    rst = 1'b1;
    bus_clash_detect = 1'b0;
    parity_error_detect = 1'b0;
    sync_loss_rst = 1'b0;
    data_port_pending = 3'h0;
    general_pending = 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(`STATUS_OFFSET, 8'h00);
    rd(`MASK_OFFSET, 8'h00);
    ev(1'b0, 1'b1);
    rd(`STATUS_OFFSET, 8'h01);
    ev(1'b1, 1'b0);
    rd(`STATUS_OFFSET, 8'h03);
    check_irq(1'b0);
    @(negedge clk);
    sync_loss_rst = 1'b1;
    @(negedge clk);
    sync_loss_rst = 1'b0;
    rd(`STATUS_OFFSET, 8'h03);
    u_ctrl_master_model.write_reg(`MASK_OFFSET, 8'h01);
    rd(`MASK_OFFSET, 8'h01);
    check_irq(1'b1);
    u_ctrl_master_model.write_reg(`STATUS_OFFSET, 8'h00);
    rd(`STATUS_OFFSET, 8'h03);
    u_ctrl_master_model.write_reg(`STATUS_OFFSET, 8'h01);
    rd(`STATUS_OFFSET, 8'h02);
    check_irq(1'b0);
    u_ctrl_master_model.write_reg(`MASK_OFFSET, 8'h02);
    rd(8'h42, 8'h00);
    check_irq(1'b1);
    u_ctrl_master_model.write_reg(`STATUS_OFFSET, 8'h02);
    rd(`STATUS_OFFSET, 8'h00);
    check_irq(1'b0);
    for (i = 0; i < 40; i++) begin
      data_port_pending = 3'($random(seed));
      general_pending = 1'($random(seed));
      clash_bit = 1'($random(seed));
      ev(clash_bit, 1'b0);
      rd(`STATUS_OFFSET, {1'b0, data_port_pending, 1'b0, general_pending, clash_bit, 1'b0});
      check_irq(clash_bit | (|data_port_pending) | general_pending);
      u_ctrl_master_model.write_reg(`STATUS_OFFSET, 8'h72);
      rd(`STATUS_OFFSET, {1'b0, data_port_pending, 1'b0, general_pending, 2'b00});
    end
    data_port_pending = 3'h0;
    general_pending = 1'b0;
    ev(1'b1, 1'b1);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd(`STATUS_OFFSET, 8'h00);
    rd(`MASK_OFFSET, 8'h00);
    check_irq(1'b0);
    repeat (3) @(negedge clk);
    if (exp_q.size() != 0) bad_count++;
    report_and_stop();
  end
endmodule : test_irq_status_port
